/* File: bop_map.svh */
`ifndef BOP_MAP_SVH
`define BOP_MAP_SVH
// Opcode top nibble values
`define BOP_OPC_CLEAR 4'h4
`define BOP_OPC_SET 4'h5
`define BOP_OPC_TEST 4'h6
// Instruction field positions
`define BOP_OPC_HI 13
`define BOP_OPC_LO 10
`define BOP_BIT_HI 9
`define BOP_BIT_LO 7
`define BOP_ADR_HI 6
`define BOP_ADR_LO 0
// Quarter phase count per instruction cycle
`define BOP_QUARTERS 4
`endif

/* File: bop_pkg.sv */
package bop_pkg;
    typedef enum logic [1:0] {
        BOP_Q1 = 2'b00,
        BOP_Q2 = 2'b01,
        BOP_Q3 = 2'b10,
        BOP_Q4 = 2'b11
    } bop_phase_t;
    typedef enum logic [1:0] {
        BOP_OP_NONE = 2'b00,
        BOP_OP_CLEAR = 2'b01,
        BOP_OP_SET = 2'b10,
        BOP_OP_TEST = 2'b11
    } bop_op_t;
endpackage

/* File: bop_phase_gen.sv */
`timescale 1ns/10ps
`default_nettype none
// Quarter phase sequencer; one clock per quarter phase.
module bop_phase_gen (
    input wire logic i_clk,
    input wire logic i_rst,
    output bop_pkg::bop_phase_t o_phase
);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_phase <= bop_pkg::BOP_Q1;
        end else begin
            o_phase <= bop_pkg::bop_phase_t'(o_phase + 2'h1);
        end
    end
endmodule
`default_nettype wire

/* File: bop_exec.sv */
`timescale 1ns/10ps
`default_nettype none
`include "bop_map.svh"
module bop_exec (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    // Instruction from fetch stage, latched at Q1
    input wire logic [13:0] I_INSTR,
    // Register file read data, valid in Q2
    input wire logic [7:0] I_RD_DATA,
    // Register file access
    output logic [6:0] O_ADDR,
    output logic O_RD_EN,
    output logic O_WR_EN,
    output logic [7:0] O_WR_DATA,
    // Pipeline control
    output logic O_FLUSH,
    output logic O_NOP_CYCLE,
    output logic [1:0] O_PHASE
);
    // ==========================================================
    // Phase sequencing
    bop_pkg::bop_phase_t phase;
    bop_phase_gen u_phase (
        .i_clk(I_CLOCK),
        .i_rst(I_SYS_RST),
        .o_phase(phase)
    );

    // ==========================================================
    // Decode
    wire [3:0] opc = I_INSTR[`BOP_OPC_HI:`BOP_OPC_LO];
    bop_pkg::bop_op_t dec_op;
    assign dec_op = (opc == `BOP_OPC_CLEAR) ? bop_pkg::BOP_OP_CLEAR :
                    (opc == `BOP_OPC_SET) ? bop_pkg::BOP_OP_SET :
                    (opc == `BOP_OPC_TEST) ? bop_pkg::BOP_OP_TEST :
                    bop_pkg::BOP_OP_NONE;

    bop_pkg::bop_op_t op_r;
    logic [2:0] bsel_r;
    logic [6:0] adr_r;
    logic [7:0] data_r;
    logic skip_r;
    logic nop_r;

    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        bit_mask = 8'h01 << b;
    endfunction

    // Whole byte rewritten, only the chosen bit altered
    wire [7:0] mod_data = (op_r == bop_pkg::BOP_OP_SET) ? (data_r | bit_mask(bsel_r)) :
                          (data_r & ~bit_mask(bsel_r));
    wire sel_bit = |(data_r & bit_mask(bsel_r));
    wire is_q1 = (phase == bop_pkg::BOP_Q1);
    wire is_q2 = (phase == bop_pkg::BOP_Q2);
    wire is_q3 = (phase == bop_pkg::BOP_Q3);
    wire is_q4 = (phase == bop_pkg::BOP_Q4);
    // In a skipped cycle the fetched word is discarded
    wire live = !skip_r;
    wire any_op = (op_r != bop_pkg::BOP_OP_NONE) && !nop_r;
    wire wr_op = (op_r == bop_pkg::BOP_OP_CLEAR) || (op_r == bop_pkg::BOP_OP_SET);

    // ==========================================================
    // Execution
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            op_r <= bop_pkg::BOP_OP_NONE;
            bsel_r <= 3'h0;
            adr_r <= 7'h00;
            data_r <= 8'h00;
            skip_r <= 1'b0;
            nop_r <= 1'b0;
            O_ADDR <= 7'h00;
            O_RD_EN <= 1'b0;
            O_WR_EN <= 1'b0;
            O_WR_DATA <= 8'h00;
            O_FLUSH <= 1'b0;
            O_NOP_CYCLE <= 1'b0;
            O_PHASE <= 2'h0;
        end else begin
            O_PHASE <= phase;
            O_RD_EN <= 1'b0;
            O_WR_EN <= 1'b0;
            O_FLUSH <= 1'b0;
            if (is_q1) begin
                // Q1 decode; a skip turns this whole cycle into a no-op
                op_r <= live ? dec_op : bop_pkg::BOP_OP_NONE;
                nop_r <= skip_r;
                O_NOP_CYCLE <= skip_r;
                skip_r <= 1'b0;
                bsel_r <= I_INSTR[`BOP_BIT_HI:`BOP_BIT_LO];
                adr_r <= I_INSTR[`BOP_ADR_HI:`BOP_ADR_LO];
                O_ADDR <= I_INSTR[`BOP_ADR_HI:`BOP_ADR_LO];
                O_RD_EN <= live && (dec_op != bop_pkg::BOP_OP_NONE);
            end
            if (is_q2 && any_op) begin
                data_r <= I_RD_DATA;
            end
            if (is_q3 && any_op) begin
                if (op_r == bop_pkg::BOP_OP_TEST) begin
                    // Bit zero skips; bit one lets the next run
                    skip_r <= !sel_bit;
                    O_FLUSH <= !sel_bit;
                end else begin
                    O_WR_DATA <= mod_data;
                    O_WR_EN <= wr_op;
                end
            end
            if (is_q4) begin
                O_ADDR <= adr_r;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bop_exec_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
// ====
// Bit op checks
module bop_exec_asserts (
    input wire logic I_CLOCK, I_SYS_RST, O_RD_EN, O_WR_EN, O_FLUSH, O_NOP_CYCLE,
    input wire logic [13:0] I_INSTR,
    input wire logic [7:0] I_RD_DATA, O_WR_DATA,
    input wire logic [6:0] O_ADDR
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);
    sequence s_read_done;
        $past(O_RD_EN, 2) && $stable(O_ADDR);
    endsequence
    a_wr_after_rd: assert property (O_WR_EN |-> s_read_done) else $error("wr");
    a_flush_after_rd: assert property (O_FLUSH |-> s_read_done) else $error("fl");
    a_wr_or_flush: assert property (!(O_WR_EN && O_FLUSH)) else $error("wf");
    a_bit_value: assert property (O_WR_EN |-> $past(I_INSTR[13:11], 3) == 3'h2 &&
        O_WR_DATA[$past(I_INSTR[9:7], 3)] == $past(I_INSTR[10], 3)) else $error("bv");
    a_byte_kept: assert property (O_WR_EN |->
        $countones(O_WR_DATA ^ $past(I_RD_DATA, 2)) <= 1) else $error("bk");
    a_rd_addr: assert property (O_RD_EN |-> O_ADDR == $past(I_INSTR[6:0])) else $error("ra");
    a_flush_test: assert property (O_FLUSH |-> $past(I_INSTR[13:10], 3) == 4'h6) else $error("ft");
    a_nop_follows: assert property (O_FLUSH |-> ##2 O_NOP_CYCLE[*4]) else $error("nf");
    a_skip_quiet: assert property (O_NOP_CYCLE |-> !O_RD_EN && !O_WR_EN) else $error("sq");
    a_rd_spacing: assert property (O_RD_EN |=> !O_RD_EN[*3]) else $error("rs");
endmodule
bind bop_exec bop_exec_asserts u_chk (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
    .O_RD_EN(O_RD_EN), .O_WR_EN(O_WR_EN), .O_FLUSH(O_FLUSH), .O_NOP_CYCLE(O_NOP_CYCLE),
    .I_INSTR(I_INSTR), .I_RD_DATA(I_RD_DATA), .O_WR_DATA(O_WR_DATA), .O_ADDR(O_ADDR));
`default_nettype wire

/* File: bop_regfile_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ====
// Register file
module bop_regfile_model (
    input wire logic i_clk, i_rd_en, i_wr_en,
    input wire logic [6:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data
);
    logic [7:0] mem [128];
    always @(posedge i_clk) begin
        if (i_wr_en) mem[i_addr] <= i_wr_data;
    end
    // Read is combinational so the byte stands in the read quarter
    // Inverted when not read, so stale bytes never look valid
    assign o_rd_data = i_rd_en ? mem[i_addr] : ~mem[i_addr];
endmodule
`default_nettype wire

/* File: bit_op_instruction_exec_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module bit_op_instruction_exec_bench;
    logic clk = 0, rst = 1, rd_en, wr_en, flush, no_operation_op;
    logic [13:0] instr = 14'h0000;
    logic [7:0] rd_data, wr_data;
    logic [6:0] addr;
    logic [1:0] phase;
    int errors = 0, tests_run = 0, cycles = 0, flushes = 0;
    // Word, byte before, byte after
    logic [29:0] rows [8] = '{{14'h1385, 8'hC7, 8'h47}, {14'h178A, 8'h0A, 8'h8A},
        {14'h107F, 8'hFF, 8'hFE}, {14'h1883, 8'h02, 8'h02}, {14'h1404, 8'h00, 8'h01},
        {14'h1883, 8'h00, 8'h00}, {14'h1404, 8'h00, 8'h00}, {14'h3C85, 8'h55, 8'h55}};
    bop_exec DUT (.I_CLOCK(clk), .I_SYS_RST(rst), .I_INSTR(instr), .I_RD_DATA(rd_data),
        .O_ADDR(addr), .O_RD_EN(rd_en), .O_WR_EN(wr_en), .O_WR_DATA(wr_data),
        .O_FLUSH(flush), .O_NOP_CYCLE(no_operation_op), .O_PHASE(phase));
    bop_regfile_model RF (.i_clk(clk), .i_rd_en(rd_en), .i_wr_en(wr_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data));
    task check(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (e !== s) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task tally_and_finish;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        flushes += int'(flush);
        // Whole run needs about 50 cycles
        if (cycles == 400) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 check("reset", 8'h00, {rd_en, wr_en, flush, no_operation_op, 4'h0});
        rst = 0;
        foreach (rows[i]) begin
            instr = rows[i][29:16];
            RF.mem[rows[i][22:16]] = rows[i][15:8];
            repeat (4) @(posedge clk);
            #1 check("reg", rows[i][7:0], RF.mem[rows[i][22:16]]);
            check("phase", 8'h03, {6'h00, phase});
            check("nop", {7'h00, i == 6}, {7'h00, no_operation_op});
        end
        check("flushes", 8'h01, 8'(flushes));
        tally_and_finish();
    end
endmodule
`default_nettype wire
